/* usbsd_pkg.sv */
// Constants shared by the descriptor responder and its configuration memory.
// Assumes a byte-wide configuration image filled by an outside loader.
package usbsd_pkg;

    // Request descriptor type codes and fixed header bytes.
    localparam logic [7:0] DT_STRING     = 8'h03;
    localparam logic [7:0] DT_BOS        = 8'h0f;
    localparam logic [7:0] DT_DEVCAP     = 8'h10;
    localparam logic [7:0] LANG_LEN      = 8'h04;
    localparam logic [7:0] BOS_LEN       = 8'h05;
    localparam logic [7:0] EXT_LEN       = 8'h07;
    localparam logic [7:0] EXT_CAP_TYPE  = 8'h02;
    localparam logic [7:0] BOS_REPLY_LEN = 8'h0c;

    // Defaults used when the configuration image is not valid.
    localparam logic [15:0] BOS_TOTAL_DEF = 16'h0016;
    localparam logic [7:0]  BOS_CAPS_DEF  = 8'h02;
    localparam logic [31:0] EXT_ATTR_DEF  = 32'h0000_0006;
    // Attribute bits that may be set; bit 0, 7:5 and 31:16 read as zero.
    localparam logic [31:0] EXT_ATTR_MASK = 32'h0000_ff1e;

    // Image layout: language code and the string length/offset table.
    localparam logic [7:0] LANGID_ADDR  = 8'h23;
    localparam logic [7:0] STR_TBL_BASE = 8'h10;
    localparam int         NUM_STR      = 5;

    // Kinds of reply the engine can stream.
    typedef enum logic [1:0] {
        K_LANG = 2'b00,
        K_STR  = 2'b01,
        K_BOS  = 2'b10
    } usbsd_kind_e;

    // Reply engine states.
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_FETCH = 2'b01,
        S_LOAD  = 2'b10,
        S_SEND  = 2'b11
    } usbsd_state_e;

endpackage

/* usbsd_cfg_if.sv */
// Bundle between the responder and its configuration image memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface usbsd_cfg_if #(parameter int AW = 8);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_data;

    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output rd_data);
    modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  input rd_data);
endinterface

/* usbsd_cfg_mem.sv */
// Byte-wide image of the configuration memory with a registered read port.
// Assumes the owner gates accesses with the shared clock enable.
`timescale 1ns/1ns
module usbsd_cfg_mem
    import usbsd_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic    clk,   // Block clock.
    input  wire logic    rst_n, // Synchronised reset, active low.
    input  wire logic    ce,    // Clock enable.
    usbsd_cfg_if.mem     bus    // Write and read port.
);
    logic [7:0] mem [2**AW];
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;

    // Storage written by the loader; contents are undefined until written.
    always_ff @(posedge clk) begin
        if (ce && bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Read data come out of a register one cycle after the request.
    always_comb begin
        rd_data_d = rd_data_q;
        if (bus.rd_en) begin
            rd_data_d = mem[bus.rd_addr];
        end
    end

    // Read register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (ce) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign bus.rd_data = rd_data_q;
endmodule

/* usbsd_top.sv */
// String, language and object-store descriptor responder.
// Assumes a control endpoint hands in decoded reads and takes bytes back.
`timescale 1ns/1ns
module usbsd_top
    import usbsd_pkg::*;
#(
    parameter int CFG_AW = 8
) (
    input  wire logic              clk,               // 100 MHz clock.
    input  wire logic              nrst,              // Async reset, low.
    input  wire logic              ce,                // Clock enable.
    input  wire logic              cfg_valid,         // Image valid, enabled.
    input  wire logic              cfg_wr_en,         // Image byte write.
    input  wire logic [CFG_AW-1:0] cfg_wr_addr,       // Image byte address.
    input  wire logic [7:0]        cfg_wr_data,       // Image byte value.
    input  wire logic [15:0]       bos_total_len_cfg, // Stored total length.
    input  wire logic [7:0]        bos_num_caps_cfg,  // Stored cap count.
    input  wire logic [31:0]       ext_attr_cfg,      // Stored attributes.
    input  wire logic              req_valid,         // Request pulse.
    input  wire logic [7:0]        req_type,          // Descriptor type.
    input  wire logic [7:0]        req_index,         // Descriptor index.
    input  wire logic [15:0]       req_length,        // Host length.
    input  wire logic              tx_ready,          // Endpoint takes byte.
    output logic                   tx_valid,          // Byte on offer.
    output logic [7:0]             tx_data,           // Reply byte.
    output logic                   tx_last,           // Final reply byte.
    output logic                   stall,             // Data stage stall.
    output logic                   busy               // Reply in progress.
);
    if (CFG_AW < 8 || CFG_AW > 16) begin : g_aw_check
        $error("CFG_AW must lie between 8 and 16.");
    end

    usbsd_cfg_if #(.AW(CFG_AW)) mem_bus ();

    logic         rst_meta_q;
    logic         rst_n_s;
    usbsd_state_e state_q, state_d;
    usbsd_kind_e  kind_q, kind_d;
    logic [7:0]   cnt_q, cnt_d;
    logic [7:0]   send_len_q, send_len_d;
    logic [7:0]   base_q, base_d;
    logic         use_mem_q, use_mem_d;
    logic [7:0]   str_len_q [NUM_STR];
    logic [7:0]   str_len_d [NUM_STR];
    logic [7:0]   str_ofs_q [NUM_STR];
    logic [7:0]   str_ofs_d [NUM_STR];
    logic         tx_valid_d, tx_last_d, stall_d, busy_d;
    logic [7:0]   tx_data_d;
    logic         any_str;
    logic [7:0]   desc_len;
    logic         refuse;
    logic [2:0]   sel;
    logic [15:0]  bos_total;
    logic [7:0]   bos_caps;
    logic [31:0]  ext_attr;

    // Reset is released through two flip-flops; assertion stays asynchronous.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_s    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_s    <= rst_meta_q;
        end
    end

    // Image address of a table entry: length first, offset second.
    function automatic logic [CFG_AW-1:0] tbl_addr(input int n,
                                                   input logic ofs);
        logic [7:0] a;
        a = STR_TBL_BASE + 8'(2 * n) + {7'h00, ofs};
        return CFG_AW'(a);
    endfunction

    // Generated byte of the object-store reply and its extension capability.
    function automatic logic [7:0] bos_byte(input logic [7:0] i,
                                            input logic [15:0] tot,
                                            input logic [7:0] caps,
                                            input logic [31:0] attr);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            8'h00:   b = BOS_LEN;
            8'h01:   b = DT_BOS;
            8'h02:   b = tot[7:0];
            8'h03:   b = tot[15:8];
            8'h04:   b = caps;
            8'h05:   b = EXT_LEN;
            8'h06:   b = DT_DEVCAP;
            8'h07:   b = EXT_CAP_TYPE;
            8'h08:   b = attr[7:0];
            8'h09:   b = attr[15:8];
            8'h0a:   b = attr[23:16];
            8'h0b:   b = attr[31:24];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Shadow the string table by snooping image writes, so the existence
    // of every string is known without a memory read at request time.
    always_comb begin
        for (int n = 0; n < NUM_STR; n++) begin
            str_len_d[n] = str_len_q[n];
            str_ofs_d[n] = str_ofs_q[n];
            if (cfg_wr_en && cfg_wr_addr == tbl_addr(n, 1'b0)) begin
                str_len_d[n] = cfg_wr_data;
            end
            if (cfg_wr_en && cfg_wr_addr == tbl_addr(n, 1'b1)) begin
                str_ofs_d[n] = cfg_wr_data;
            end
        end
    end

    // String table shadow registers.
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int n = 0; n < NUM_STR; n++) begin
                str_len_q[n] <= 8'h00;
                str_ofs_q[n] <= 8'h00;
            end
        end else if (ce) begin
            for (int n = 0; n < NUM_STR; n++) begin
                str_len_q[n] <= str_len_d[n];
                str_ofs_q[n] <= str_ofs_d[n];
            end
        end
    end

    // Effective object-store fields: stored when valid, defaults otherwise.
    always_comb begin
        any_str = 1'b0;
        for (int n = 0; n < NUM_STR; n++) begin
            any_str = any_str | (str_len_q[n] != 8'h00);
        end
        bos_total = cfg_valid ? bos_total_len_cfg : BOS_TOTAL_DEF;
        bos_caps  = cfg_valid ? bos_num_caps_cfg : BOS_CAPS_DEF;
        ext_attr  = (cfg_valid ? ext_attr_cfg : EXT_ATTR_DEF)
                    & EXT_ATTR_MASK;
        sel       = 3'(req_index - 8'h01);
    end

    // Request decode: the requested language code is not an input at all.
    always_comb begin
        kind_d    = K_BOS;
        base_d    = 8'h00;
        desc_len  = BOS_REPLY_LEN;
        refuse    = 1'b0;
        if (req_type == DT_STRING && req_index == 8'h00) begin
            kind_d   = K_LANG;
            desc_len = LANG_LEN;
            refuse   = !cfg_valid || !any_str;
        end else if (req_type == DT_STRING) begin
            kind_d = K_STR;
            if (req_index > 8'(NUM_STR)) begin
                refuse = 1'b1;
            end else begin
                desc_len = str_len_q[sel];
                base_d   = str_ofs_q[sel];
                refuse   = !cfg_valid || str_len_q[sel] == 8'h00;
            end
        end else if (req_type != DT_BOS) begin
            refuse = 1'b1;
        end
    end

    // Reply engine: each byte is fetched, loaded, then held until taken.
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        send_len_d = send_len_q;
        use_mem_d  = use_mem_q;
        tx_valid_d = tx_valid;
        tx_data_d  = tx_data;
        tx_last_d  = tx_last;
        stall_d    = 1'b0;
        busy_d     = busy;
        mem_bus.rd_en   = 1'b0;
        mem_bus.rd_addr = '0;
        case (state_q)
            S_IDLE: begin
                if (req_valid) begin
                    cnt_d = 8'h00;
                    if (req_length < {8'h00, desc_len}) begin
                        send_len_d = req_length[7:0];
                    end else begin
                        send_len_d = desc_len;
                    end
                    if (refuse) begin
                        stall_d = 1'b1;
                    end else if (req_length != 16'h0000) begin
                        busy_d  = 1'b1;
                        state_d = S_FETCH;
                    end
                end
            end
            S_FETCH: begin
                use_mem_d = 1'b0;
                if (kind_q == K_STR) begin
                    use_mem_d       = 1'b1;
                    mem_bus.rd_en   = 1'b1;
                    mem_bus.rd_addr = CFG_AW'(base_q + cnt_q);
                end else if (kind_q == K_LANG && cnt_q >= 8'h02) begin
                    use_mem_d       = 1'b1;
                    mem_bus.rd_en   = 1'b1;
                    mem_bus.rd_addr = CFG_AW'(LANGID_ADDR + cnt_q
                                              - 8'h02);
                end
                state_d = S_LOAD;
            end
            S_LOAD: begin
                if (use_mem_q) begin
                    tx_data_d = mem_bus.rd_data;
                end else if (kind_q == K_LANG) begin
                    tx_data_d = (cnt_q == 8'h00) ? LANG_LEN
                                                 : DT_STRING;
                end else begin
                    tx_data_d = bos_byte(cnt_q, bos_total, bos_caps,
                                         ext_attr);
                end
                tx_valid_d = 1'b1;
                tx_last_d  = (cnt_q == send_len_q - 8'h01);
                state_d    = S_SEND;
            end
            S_SEND: begin
                if (tx_ready) begin
                    tx_valid_d = 1'b0;
                    tx_last_d  = 1'b0;
                    cnt_d      = cnt_q + 8'h01;
                    if (tx_last) begin
                        busy_d  = 1'b0;
                        state_d = S_IDLE;
                    end else begin
                        state_d = S_FETCH;
                    end
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Reply engine registers; kind and base only move when a request lands.
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_q    <= S_IDLE;
            kind_q     <= K_LANG;
            base_q     <= 8'h00;
            cnt_q      <= 8'h00;
            send_len_q <= 8'h00;
            use_mem_q  <= 1'b0;
            tx_valid   <= 1'b0;
            tx_data    <= 8'h00;
            tx_last    <= 1'b0;
            stall      <= 1'b0;
            busy       <= 1'b0;
        end else if (ce) begin
            state_q    <= state_d;
            if (state_q == S_IDLE && req_valid) begin
                kind_q <= kind_d;
                base_q <= base_d;
            end
            cnt_q      <= cnt_d;
            send_len_q <= send_len_d;
            use_mem_q  <= use_mem_d;
            tx_valid   <= tx_valid_d;
            tx_data    <= tx_data_d;
            tx_last    <= tx_last_d;
            stall      <= stall_d;
            busy       <= busy_d;
        end
    end

    // Loader writes pass straight to the image.
    assign mem_bus.wr_en   = cfg_wr_en;
    assign mem_bus.wr_addr = cfg_wr_addr;
    assign mem_bus.wr_data = cfg_wr_data;

    usbsd_cfg_mem #(.AW(CFG_AW)) u_mem (
        .clk   (clk),
        .rst_n (rst_n_s),
        .ce    (ce),
        .bus   (mem_bus.mem)
    );
endmodule

/* usbsd_props.sv */
// Checker for the reply stream of the descriptor responder.
// Assumes ce stays high while requests run and binds onto usbsd_top.
`timescale 1ns/1ns
module usbsd_props
    import usbsd_pkg::*;
(
    input wire logic        clk,        // Clock.
    input wire logic        nrst,       // Reset, active low.
    input wire logic        ce,         // Clock enable.
    input wire logic        cfg_valid,  // Image valid.
    input wire logic        req_valid,  // Request pulse.
    input wire logic [7:0]  req_type,   // Descriptor type.
    input wire logic [7:0]  req_index,  // Descriptor index.
    input wire logic [15:0] req_length, // Host length.
    input wire logic        tx_ready,   // Byte taken.
    input wire logic        tx_valid,   // Byte on offer.
    input wire logic [7:0]  tx_data,    // Reply byte.
    input wire logic        tx_last,    // Final byte.
    input wire logic        stall,      // Stall pulse.
    input wire logic        busy        // Reply running.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // A request that the idle engine accepts.
    logic take;
    assign take = ce && req_valid && !busy && req_length != 16'h0000;

    // Steps of a reply: gap between bytes, and accepted non-stalled takes.
    sequence s_gap;
        !tx_valid ##1 !tx_valid ##1 tx_valid;
    endsequence
    sequence s_lang_take;
        take && req_type == DT_STRING && req_index == 8'h00 ##1 !stall;
    endsequence
    sequence s_bos_take;
        take && req_type == DT_BOS ##1 !stall;
    endsequence

    a_stall_one_cycle: assert property (stall |=> !stall)
        else $error("stall lasted more than one cycle");
    a_byte_holds: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("offered byte changed before it was taken");
    a_byte_gap: assert property (tx_valid && tx_ready && !tx_last
        |=> s_gap)
        else $error("next byte not offered three cycles later");
    a_last_releases: assert property (tx_valid && tx_ready && tx_last
        |=> !busy && !tx_valid)
        else $error("reply went on after its final byte");
    a_lang_header: assert property (s_lang_take
        |-> ##2 tx_valid && tx_data == LANG_LEN)
        else $error("language reply did not open with length four");
    a_bos_header: assert property (s_bos_take
        |-> ##2 tx_valid && tx_data == BOS_LEN)
        else $error("object store reply did not open with length five");
    a_invalid_stall: assert property (take && req_type == DT_STRING
        && !cfg_valid |=> stall)
        else $error("string read without an image did not stall");
    a_index_stall: assert property (take && req_type == DT_STRING
        && req_index > 8'h05 |=> stall)
        else $error("string index above five did not stall");
    a_one_byte_last: assert property (take && req_length == 16'h0001
        ##1 !stall |-> ##2 tx_valid && tx_last)
        else $error("one byte request did not end on its first byte");
endmodule

bind usbsd_top usbsd_props u_props (
    .clk(clk), .nrst(nrst), .ce(ce), .cfg_valid(cfg_valid),
    .req_valid(req_valid), .req_type(req_type), .req_index(req_index),
    .req_length(req_length), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .stall(stall), .busy(busy)
);

/* usbsd_host_model.sv */
// Control endpoint partner that takes reply bytes promptly or slowly.
// Assumes the bench empties the byte queue before each request.
`timescale 1ns/1ns
module usbsd_host_model (
    input  wire logic       clk,      // Clock.
    input  wire logic       slow,     // Accept only every fourth cycle.
    input  wire logic       tx_valid, // Byte on offer.
    input  wire logic [7:0] tx_data,  // Reply byte.
    output logic            tx_ready  // Byte taken this edge.
);
    logic [7:0] got[$];
    logic [1:0] cnt_q = 2'h0;

    initial tx_ready = 1'b0;

    // Stores each taken byte; in slow mode stretches acceptance.
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        cnt_q <= cnt_q + 2'h1;
        tx_ready <= !slow || cnt_q == 2'h3;
    end
endmodule

/* usbsd_top_test.sv */
// Self-checking bench for the descriptor responder.
// Assumes the endpoint partner model and the bound checker.
`timescale 1ns/1ns
module usbsd_top_test
    import usbsd_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ce = 1'b1;
    logic        cfg_valid = 1'b0;
    logic        cfg_wr_en = 1'b0;
    logic [7:0]  cfg_wr_addr = 8'h00;
    logic [7:0]  cfg_wr_data = 8'h00;
    logic [15:0] bos_total = 16'h0000;
    logic [7:0]  bos_caps = 8'h00;
    logic [31:0] ext_attr = 32'h0000_0000;
    logic        req_valid = 1'b0;
    logic [7:0]  req_type = 8'h00;
    logic [7:0]  req_index = 8'h00;
    logic [15:0] req_length = 16'h0000;
    logic        slow = 1'b0;
    logic        tx_ready, tx_valid, tx_last, stall, busy;
    logic [7:0]  tx_data;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    usbsd_top u_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .cfg_valid(cfg_valid),
        .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
        .cfg_wr_data(cfg_wr_data), .bos_total_len_cfg(bos_total),
        .bos_num_caps_cfg(bos_caps), .ext_attr_cfg(ext_attr),
        .req_valid(req_valid), .req_type(req_type), .req_index(req_index),
        .req_length(req_length), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .stall(stall), .busy(busy)
    );

    usbsd_host_model u_host (
        .clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready)
    );

    // Compares one byte-wide result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one flag.
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Writes one image byte.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr_en <= 1'b1;
        cfg_wr_addr <= a;
        cfg_wr_data <= d;
        @(posedge clk);
        cfg_wr_en <= 1'b0;
    endtask

    // Issues one read and checks the stall and the bytes, first byte left.
    task automatic run(input logic [7:0] ty, input logic [7:0] ix,
                       input logic [15:0] ln, input logic [95:0] exp,
                       input int n);
        int w;
        u_host.got.delete();
        @(posedge clk);
        req_valid <= 1'b1;
        req_type <= ty;
        req_index <= ix;
        req_length <= ln;
        @(posedge clk);
        req_valid <= 1'b0;
        // The stall pulse stands only in the cycle after the request lands.
        @(negedge clk);
        chk1(stall, n == 0);
        w = 0;
        while (busy === 1'b1 && w < 400) begin
            @(negedge clk);
            w++;
        end
        chk8(8'(u_host.got.size()), 8'(n));
        for (int i = 0; i < n && i < u_host.got.size(); i++) begin
            chk8(u_host.got[i], exp[95-8*i -: 8]);
        end
    endtask

    // Without an image every string stalls and the object store defaults.
    task automatic t_no_image();
        run(DT_STRING, 8'h00, 16'h00ff, 96'h0, 0);
        run(DT_STRING, 8'h01, 16'h00ff, 96'h0, 0);
        run(DT_BOS, 8'h00, 16'h00ff, 96'h050f_1600_0207_1002_0600_0000,
            12);
    endtask

    // Language and string replies from a programmed image, slow endpoint.
    task automatic t_strings();
        logic [47:0] s;
        s = 48'h0603_4100_4200;
        @(posedge clk);
        cfg_valid <= 1'b1;
        run(DT_STRING, 8'h00, 16'h00ff, 96'h0, 0);
        wr(8'h23, 8'h09);
        wr(8'h24, 8'h04);
        wr(8'h12, 8'h06);
        wr(8'h13, 8'h40);
        for (int i = 0; i < 6; i++) begin
            wr(8'h40 + 8'(i), s[47-8*i -: 8]);
        end
        slow <= 1'b1;
        run(DT_STRING, 8'h00, 16'h00ff, {32'h0403_0904, 64'h0},
            4);
        run(DT_STRING, 8'h02, 16'h00ff, {s, 48'h0}, 6);
        run(DT_STRING, 8'h02, 16'h0002, {16'h0603, 80'h0}, 2);
        run(DT_STRING, 8'h00, 16'h0001, {8'h04, 88'h0}, 1);
        run(DT_STRING, 8'h01, 16'h00ff, 96'h0, 0);
        run(DT_STRING, 8'h06, 16'h00ff, 96'h0, 0);
    endtask

    // Object store fields from the image, attributes masked, then cut.
    task automatic t_bos_cfg();
        @(posedge clk);
        slow <= 1'b0;
        bos_total <= 16'h1234;
        bos_caps <= 8'h05;
        ext_attr <= 32'hffff_ffff;
        run(DT_BOS, 8'h00, 16'h00ff, 96'h050f_3412_0507_1002_1eff_0000,
            12);
        run(DT_BOS, 8'h00, 16'h0003, {24'h050f34, 72'h0}, 3);
    endtask

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    // Reset, then the scenarios in order.
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_no_image();
        t_strings();
        t_bos_cfg();
        give_verdict();
    end
endmodule
